// [hdl/mem_cycle_ctrl.v]
// Main-memory cycle controller working beside the cache controller
// Operation
// - Decode starts alongside cache lookup
// - Hits: cache owns cycle, DRAM idle
// - Read miss: fetch line to CPU, cache
// - Dirty read miss: write victim line back
// - Write miss: DRAM alone writes memory
// - Burst reads up to 128 bytes
// - Memory path 64 data, 8 parity
// - One parity bit per byte lane
// - Four banks of by-36 modules
// - Bank needs two by-36 modules
// - 640K low, 768MB extended decode
// - Boot ROM at 4GB top, 1MB top
// - Reset fetch from ROM at FFFFFFF0
// - Shadow serves BIOS ranges from DRAM
`include "mem_cycle_regs.vh"
module mem_cycle_ctrl (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        ads_in,
  input  wire [31:0] addr_in,
  input  wire        write_in,
  input  wire [4:0]  burst_beats_in,
  input  wire [63:0] wdata_in,
  input  wire        lookup_done_in,
  input  wire        hit_in,
  input  wire        dirty_in,
  input  wire [31:0] victim_addr_in,
  input  wire [63:0] victim_data_in,
  input  wire        shadow_en_in,
  input  wire [3:0]  bank_present_in,
  input  wire        mem_ack_in,
  input  wire [71:0] mem_rdata_in,
  input  wire [7:0]  rom_data_in,
  output reg         busy_out,
  output reg         victim_req_out,
  output reg         rdy_out,
  output reg  [63:0] rdata_out,
  output reg         cache_fill_out,
  output reg         mem_req_out,
  output reg         mem_we_out,
  output reg  [3:0]  bank_sel_out,
  output reg  [31:0] mem_addr_out,
  output reg  [71:0] mem_wdata_out,
  output reg         rom_cs_out,
  output reg  [16:0] rom_addr_out,
  output reg  [7:0]  par_err_out,
  output reg         decode_err_out
);
  localparam ST_IDLE   = 3'h0;
  localparam ST_DECODE = 3'h1;
  localparam ST_VICTIM = 3'h2;
  localparam ST_FILL   = 3'h3;
  localparam ST_WRITE  = 3'h4;
  localparam ST_ROM    = 3'h5;
  localparam ST_DONE   = 3'h6;

  localparam TGT_NONE = 2'h0;
  localparam TGT_DRAM = 2'h1;
  localparam TGT_ROM  = 2'h2;

  // Latched cycle and sequencing state
  reg [2:0]  state;
  reg [31:0] cyc_addr;
  reg        cyc_write;
  reg [4:0]  beats_left;
  reg [1:0]  target;
  reg [3:0]  bank_hit;
  reg [7:0]  rom_beat;
  reg [63:0] rom_word;
  // Parity lanes of write and read data
  wire [7:0] wr_par;
  wire [7:0] rd_par_err;
  wire [63:0] par_src;

  // Address map decode, taken with the cycle start
  function [1:0] map_target;
    input [31:0] a;
    input        shadow;
    begin
      if (a >= `ROM_HI_BASE)
        map_target = TGT_ROM;
      else if (a >= `ROM_LO_BASE && a < `ONE_MB)
        map_target = shadow ? TGT_DRAM : TGT_ROM;
      else if (a >= `VBIOS_BASE && a < `VBIOS_TOP)
        map_target = shadow ? TGT_DRAM : TGT_NONE;
      else if (a < `LOW_DRAM_TOP)
        map_target = TGT_DRAM;
      else if (a >= `ONE_MB && a < `EXT_DRAM_TOP)
        map_target = TGT_DRAM;
      else
        map_target = TGT_NONE;
    end
  endfunction

  // Bank select from address, one of four by-36 pairs
  function [3:0] bank_of;
    input [31:0] a;
    reg   [31:0] off;
    begin
      off = (a >= `ONE_MB) ? a - `ONE_MB : 32'h00000000;
      if (off < `BANK_SIZE)             bank_of = 4'h1;
      else if (off < 2 * `BANK_SIZE)    bank_of = 4'h2;
      else if (off < 3 * `BANK_SIZE)    bank_of = 4'h4;
      else                              bank_of = 4'h8;
    end
  endfunction

  // Burst length: zero means one beat, the top clamps at the maximum
  function [4:0] clamp_beats;
    input [4:0] n;
    begin
      if (n == 5'h00)
        clamp_beats = 5'h01;
      else if (n > `BURST_MAX_BEATS)
        clamp_beats = 5'h10;
      else
        clamp_beats = n;
    end
  endfunction

  // Parity source: processor data on writes, victim line on read misses
  assign par_src = cyc_write ? wdata_in : victim_data_in;

  // Parity generation on write data and check on read data
  byte_parity u_wpar (
    .data_in (par_src),
    .par_in  (8'h00),
    .par_out (wr_par),
    .err_out ()
  );
  byte_parity u_rpar (
    .data_in (mem_rdata_in[63:0]),
    .par_in  (mem_rdata_in[71:64]),
    .par_out (),
    .err_out (rd_par_err)
  );

  // Cycle sequencer
  always @(posedge clk_in) begin
    if (rst_in) begin
      state          <= ST_IDLE;
      cyc_addr       <= 32'h00000000;
      cyc_write      <= 1'b0;
      beats_left     <= 5'h00;
      target         <= TGT_NONE;
      bank_hit       <= 4'h0;
      rom_beat       <= 8'h00;
      rom_word       <= 64'h0000000000000000;
      busy_out       <= 1'b0;
      victim_req_out <= 1'b0;
      rdy_out        <= 1'b0;
      rdata_out      <= 64'h0000000000000000;
      cache_fill_out <= 1'b0;
      mem_req_out    <= 1'b0;
      mem_we_out     <= 1'b0;
      bank_sel_out   <= 4'h0;
      mem_addr_out   <= 32'h00000000;
      mem_wdata_out  <= 72'h000000000000000000;
      rom_cs_out     <= 1'b0;
      rom_addr_out   <= 17'h00000;
      par_err_out    <= 8'h00;
      decode_err_out <= 1'b0;
    end else begin
      rdy_out        <= 1'b0;
      cache_fill_out <= 1'b0;
      decode_err_out <= 1'b0;
      case (state)
        // Wait for a cycle start
        ST_IDLE: begin
          mem_req_out <= 1'b0;
          rom_cs_out  <= 1'b0;
          if (ads_in) begin
            // Decode begins now, before the cache answers
            cyc_addr   <= addr_in;
            cyc_write  <= write_in;
            target     <= map_target(addr_in, shadow_en_in);
            bank_hit   <= bank_of(addr_in);
            beats_left <= clamp_beats(burst_beats_in);
            busy_out   <= 1'b1;
            state      <= ST_DECODE;
          end
        end

        // Cache answer picks who serves the cycle
        ST_DECODE: begin
          if (lookup_done_in) begin
            // Boot ROM read, byte-wide sequence
            if (target == TGT_ROM && !cyc_write) begin
              rom_cs_out   <= 1'b1;
              rom_addr_out <= cyc_addr[16:0];
              rom_beat     <= 8'h00;
              state        <= ST_ROM;
            end else if (target == TGT_NONE || (target == TGT_DRAM &&
                         (bank_hit & bank_present_in) == 4'h0)) begin
              // Unmapped or empty bank: finish without memory
              decode_err_out <= 1'b1;
              rdy_out        <= 1'b1;
              state          <= ST_DONE;
            end else if (hit_in || target == TGT_ROM) begin
              // Cache serves hits; writes to ROM are dropped
              state <= ST_DONE;
            end else if (cyc_write) begin
              // Write miss goes straight to memory
              mem_req_out   <= 1'b1;
              mem_we_out    <= 1'b1;
              bank_sel_out  <= bank_hit;
              mem_addr_out  <= cyc_addr;
              mem_wdata_out <= {wr_par, wdata_in};
              state         <= ST_WRITE;
            end else if (dirty_in) begin
              // First victim beat must already stand with the request
              mem_wdata_out  <= {wr_par, victim_data_in};
              victim_req_out <= 1'b1;
              mem_req_out    <= 1'b1;
              mem_we_out     <= 1'b1;
              bank_sel_out   <= bank_of(victim_addr_in);
              mem_addr_out   <= victim_addr_in;
              beats_left     <= beats_left;
              state          <= ST_VICTIM;
            end else begin
              mem_req_out  <= 1'b1;
              mem_we_out   <= 1'b0;
              bank_sel_out <= bank_hit;
              mem_addr_out <= cyc_addr;
              state        <= ST_FILL;
            end
          end
        end

        // Write-back of the victim line
        ST_VICTIM: begin
          // Copy back one beat of the victim line per accepted access
          mem_wdata_out <= {wr_par, victim_data_in};
          if (mem_ack_in) begin
            if (rom_beat == `LINE_BEATS - 1) begin
              rom_beat       <= 8'h00;
              victim_req_out <= 1'b0;
              mem_we_out     <= 1'b0;
              bank_sel_out   <= bank_hit;
              mem_addr_out   <= cyc_addr;
              state          <= ST_FILL;
            end else begin
              rom_beat     <= rom_beat + 8'h01;
              mem_addr_out <= mem_addr_out + 32'h00000008;
            end
          end
        end

        // Line fill, one beat per accepted read
        ST_FILL: begin
          if (mem_ack_in) begin
            rdata_out      <= mem_rdata_in[63:0];
            rdy_out        <= 1'b1;
            cache_fill_out <= 1'b1;
            par_err_out    <= par_err_out | rd_par_err;
            mem_addr_out   <= mem_addr_out + 32'h00000008;
            beats_left     <= beats_left - 5'h01;
            if (beats_left == 5'h01) begin
              mem_req_out <= 1'b0;
              state       <= ST_DONE;
            end
          end
        end

        // Single write beat of a write miss
        ST_WRITE: begin
          if (mem_ack_in) begin
            mem_req_out <= 1'b0;
            mem_we_out  <= 1'b0;
            rdy_out     <= 1'b1;
            state       <= ST_DONE;
          end
        end

        // Boot ROM byte sequence
        ST_ROM: begin
          // Assemble a 64-bit word from eight byte reads of the 8-bit ROM
          rom_word     <= {rom_data_in, rom_word[63:8]};
          rom_addr_out <= rom_addr_out + 17'h00001;
          rom_beat     <= rom_beat + 8'h01;
          if (rom_beat == 8'h07) begin
            rdata_out  <= {rom_data_in, rom_word[63:8]};
            rdy_out    <= 1'b1;
            rom_cs_out <= 1'b0;
            rom_beat   <= 8'h00;
            state      <= ST_DONE;
          end
        end

        // Release busy, back to idle
        ST_DONE: begin
          busy_out <= 1'b0;
          state    <= ST_IDLE;
        end

        // Unused codes fall back to idle
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// [hdl/mem_cycle_regs.vh]
// Constants for the main-memory cycle controller
`ifndef MEM_CYCLE_REGS_VH
`define MEM_CYCLE_REGS_VH
`define DATA_W          64
`define PAR_W           8
`define MEM_W           72
`define BANKS           4
`define BURST_MAX_BEATS 16
`define BEAT_CNT_W      5
`define LINE_BEATS      4
`define LOW_DRAM_TOP    32'h000A0000
`define ONE_MB          32'h00100000
`define EXT_DRAM_TOP    32'h30100000
`define ROM_HI_BASE     32'hFFFE0000
`define ROM_LO_BASE     32'h000E0000
`define VBIOS_BASE      32'h000C0000
`define VBIOS_TOP       32'h000C8000
`define RESET_VECTOR    32'hFFFFFFF0
`define BANK_SIZE       32'h0C000000
`define ROM_ADDR_W      17
`endif

// [hdl/byte_parity.v]
// Per-byte even parity generation and lane compare
module byte_parity (
  input  wire [63:0] data_in,
  input  wire [7:0]  par_in,
  output wire [7:0]  par_out,
  output wire [7:0]  err_out
);
  genvar g;
  // One parity bit per byte lane
  generate
    for (g = 0; g < 8; g = g + 1) begin : lane
      assign par_out[g] = ^data_in[g*8+7:g*8];
      assign err_out[g] = par_out[g] ^ par_in[g];
    end
  endgenerate
endmodule

// [verif/mem_cycle_ctrl_checker.sv]
// Port assertions for the memory cycle controller
module mem_cycle_ctrl_checker (
  input logic        clk_in,
  input logic        rst_in,
  input logic        ads_in,
  input logic        lookup_done_in,
  input logic        hit_in,
  input logic        mem_ack_in,
  input logic        busy_out,
  input logic        victim_req_out,
  input logic        rdy_out,
  input logic        cache_fill_out,
  input logic        mem_req_out,
  input logic        mem_we_out,
  input logic [3:0]  bank_sel_out,
  input logic [71:0] mem_wdata_out,
  input logic        decode_err_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Even parity of each byte lane
  function automatic logic [7:0] lane_par(input logic [63:0] v);
    for (int i = 0; i < 8; i++)
      lane_par[i] = ^v[8*i+:8];
  endfunction
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // Each property ties an output to its cause
  ads_taken_a: assert property (ads_in && !busy_out |=> busy_out)
    else $error("cycle start not taken");
  hit_no_dram_a: assert property ($rose(busy_out) && lookup_done_in && hit_in |-> (!mem_req_out) [*3])
    else $error("memory used on a hit");
  victim_write_a: assert property (victim_req_out && mem_req_out |-> mem_we_out)
    else $error("write-back beat not a write");
  fill_with_rdy_a: assert property (cache_fill_out |-> rdy_out && !mem_we_out)
    else $error("fill without read beat");
  write_done_a: assert property (mem_req_out && mem_we_out && mem_ack_in && !victim_req_out |=> rdy_out && !mem_req_out)
    else $error("write miss not finished");
  write_parity_a: assert property (mem_req_out && mem_we_out |-> mem_wdata_out[71:64] == lane_par(mem_wdata_out[63:0]))
    else $error("bad write parity");
  bank_onehot_a: assert property (mem_req_out |-> $onehot(bank_sel_out))
    else $error("bank select not one-hot");
  decode_err_a: assert property (decode_err_out |-> !mem_req_out ##1 !decode_err_out)
    else $error("decode error not a clean pulse");
endmodule

bind mem_cycle_ctrl mem_cycle_ctrl_checker chk_u (.clk_in, .rst_in, .ads_in, .lookup_done_in,
  .hit_in, .mem_ack_in, .busy_out, .victim_req_out, .rdy_out, .cache_fill_out, .mem_req_out,
  .mem_we_out, .bank_sel_out, .mem_wdata_out, .decode_err_out);

// [verif/dram_rom_model.sv]
// Memory array and boot ROM stand-in on the far side
module dram_rom_model (
  input  logic        clk_in,
  input  logic        slow_in,
  input  logic        bad_par_in,
  input  logic        req_in,
  input  logic        we_in,
  input  logic [31:0] addr_in,
  input  logic [71:0] wdata_in,
  input  logic [16:0] rom_addr_in,
  output logic        ack_out,
  output logic [71:0] rdata_out,
  output logic [7:0]  rom_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0]  wait_cnt;
  logic [63:0] d;
  logic [71:0] last_wr;
  logic [31:0] last_wr_addr;
  int          wr_cnt = 0;
  // Even parity of each byte lane
  function automatic logic [7:0] lane_par(input logic [63:0] v);
    for (int i = 0; i < 8; i++)
      lane_par[i] = ^v[8*i+:8];
  endfunction
  // ROM byte answers its address within the same cycle
  assign rom_data_out = rom_addr_in[7:0] + 8'h1;
  // Beat follows the address; idle bus shows the inverse
  assign d = {~addr_in, addr_in};
  assign rdata_out = {lane_par(d) ^ {7'h0, bad_par_in}, d} ^ {72{!ack_out}};
  // One ack per beat, prompt or after three cycles
  always @(posedge clk_in) begin
    ack_out <= req_in && !ack_out && wait_cnt == 2'h0;
    wait_cnt <= (!req_in || ack_out) ? {slow_in, slow_in} : wait_cnt - 2'h1;
    if (req_in && we_in && !ack_out && wait_cnt == 2'h0) begin
      last_wr <= wdata_in;
      last_wr_addr <= addr_in;
      wr_cnt <= wr_cnt + 1;
    end
  end
endmodule

// [verif/cache_dram_cycle_control_test.sv]
// Self-checking bench for the memory cycle controller
module cache_dram_cycle_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in = 1'h0, rst_in = 1'h1, ads_in = 1'h0, write_in = 1'h0, hit_in = 1'h0;
  logic        lookup_done_in = 1'h0, dirty_in = 1'h0, shadow_en_in = 1'h0, slow = 1'h0;
  logic        bad_par = 1'h0, busy_out, victim_req_out, rdy_out, cache_fill_out, mem_req_out;
  logic        mem_we_out, rom_cs_out, decode_err_out, mem_ack_in;
  logic [3:0]  bank_present_in = 4'hF, bank_sel_out, bank;
  logic [4:0]  burst_beats_in = 5'h0;
  logic [7:0]  rom_data_in, par_err_out;
  logic [16:0] rom_addr_out;
  logic [31:0] addr_in = 32'h0, victim_addr_in = 32'h0, mem_addr_out, a;
  logic [63:0] wdata_in = 64'h0, victim_data_in = 64'h0, rdata_out, w, got[$];
  logic [71:0] mem_rdata_in, mem_wdata_out;
  logic [31:0] rom_tbl[3] = '{32'hFFFFFFF0, 32'h000F0008, 32'h000FFFF8};
  logic [31:0] adr_tbl[4] = '{32'h000C0000, 32'h000E0000, 32'h000A0000, 32'h30100000};
  int          nb_tbl[6] = '{0, 4, 16, 17, 1, 5};
  int          error_cnt = 0, total_checks = 0, cyc = 0, fills, reqs, roms, errs, n, wc;
  mem_cycle_ctrl dut_u (.clk_in(clk_in), .rst_in(rst_in), .ads_in(ads_in), .addr_in(addr_in),
    .write_in(write_in), .burst_beats_in(burst_beats_in), .wdata_in(wdata_in),
    .lookup_done_in(lookup_done_in), .hit_in(hit_in), .dirty_in(dirty_in),
    .victim_addr_in(victim_addr_in), .victim_data_in(victim_data_in),
    .shadow_en_in(shadow_en_in), .bank_present_in(bank_present_in), .mem_ack_in(mem_ack_in),
    .mem_rdata_in(mem_rdata_in), .rom_data_in(rom_data_in), .busy_out(busy_out),
    .victim_req_out(victim_req_out), .rdy_out(rdy_out), .rdata_out(rdata_out),
    .cache_fill_out(cache_fill_out), .mem_req_out(mem_req_out), .mem_we_out(mem_we_out),
    .bank_sel_out(bank_sel_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
    .rom_cs_out(rom_cs_out), .rom_addr_out(rom_addr_out), .par_err_out(par_err_out),
    .decode_err_out(decode_err_out));
  dram_rom_model dm_u (.clk_in(clk_in), .slow_in(slow), .bad_par_in(bad_par),
    .req_in(mem_req_out),
    .we_in(mem_we_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
    .rom_addr_in(rom_addr_out), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in),
    .rom_data_out(rom_data_in));
  initial forever #50 clk_in = ~clk_in;
  // Output observation and run limit
  always @(negedge clk_in) begin
    if (rdy_out === 1'h1)
      got.push_back(rdata_out);
    if (mem_req_out === 1'h1)
      bank = bank_sel_out;
    fills += int'(cache_fill_out === 1'h1);
    reqs += int'(mem_req_out === 1'h1);
    roms += int'(rom_cs_out === 1'h1);
    errs += int'(decode_err_out === 1'h1);
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic check(input logic [71:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One processor cycle, waits for the controller to go idle
  task automatic run(input logic [31:0] ad, input logic wr, ht, dt, input logic [4:0] nb);
    got.delete();
    {fills, reqs, roms, errs} = 128'h0;
    {addr_in, write_in, hit_in, dirty_in, burst_beats_in} = {ad, wr, ht, dt, nb};
    wdata_in = {$urandom, $urandom};
    victim_data_in = {$urandom, $urandom};
    victim_addr_in = {$urandom} % 32'h9F000 & 32'hFFFFFFE0;
    lookup_done_in = 1'h1;
    ads_in = 1'h1;
    @(negedge clk_in);
    ads_in = 1'h0;
    for (int k = 0; k < 400 && busy_out !== 1'h0; k++)
      @(negedge clk_in);
    if (busy_out !== 1'h0) begin
      error_cnt++;
      $display("Error %0t ns: cycle did not end", $time);
    end
    @(negedge clk_in);
  endtask
  task automatic finish_test();
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    void'($urandom(32'h6086D9E5));
    repeat (12) @(negedge clk_in);
    rst_in = 1'h0;
    foreach (rom_tbl[i]) begin
      run(rom_tbl[i], 1'h0, 1'h0, 1'h0, 5'h1);
      for (int j = 0; j < 8; j++)
        w[8*j+:8] = rom_tbl[i][7:0] + 8'h1 + 8'(j);
      check(got[0], w);
      check(roms, 8);
      check(reqs, 0);
    end
    run(32'h000F0000, 1'h1, 1'h0, 1'h0, 5'h1);
    check(reqs, 0);
    shadow_en_in = 1'h1;
    for (int i = 0; i < 4; i++) begin
      run(adr_tbl[i], 1'h0, 1'h0, 1'h0, 5'h1);
      check(i > 1 ? errs : roms, i > 1);
      check(i > 1 ? reqs : got[0], i > 1 ? 0 : {~adr_tbl[i], adr_tbl[i]});
    end
    for (int i = 0; i < 8; i++) begin
      slow = i[1];
      a = (i[0] ? 32'h00100000 : 32'h0) + ({$urandom} % 32'h9F000 & 32'hFFFFFFF8);
      run(a, i[0], i < 2, 1'h0, 5'h1);
      check(reqs == 0, i < 2);
      if (i > 1 && i[0]) begin
        check(dm_u.last_wr, {dm_u.lane_par(wdata_in), wdata_in});
        check(dm_u.last_wr_addr, a);
      end
    end
    foreach (nb_tbl[i]) begin
      a = (i[1] ? 32'h00100000 : 32'h0) + ({$urandom} % 32'h9F000 & 32'hFFFFFFF8);
      wc = dm_u.wr_cnt;
      n = nb_tbl[i] == 0 ? 1 : nb_tbl[i] > 16 ? 16 : nb_tbl[i];
      run(a, 1'h0, 1'h0, i[0], 5'(nb_tbl[i]));
      check({got.size(), fills}, {n, n});
      check(dm_u.wr_cnt - wc, i[0] ? 4 : 0);
      if (i[0]) begin
        check(dm_u.last_wr_addr, victim_addr_in + 32'h18);
        check(dm_u.last_wr[63:0], victim_data_in);
        check(dm_u.last_wr[71:64], dm_u.lane_par(victim_data_in));
      end
      for (int j = 0; j < n; j++)
        check(got[j], {~(a + 32'(8 * j)), a + 32'(8 * j)});
    end
    for (int i = 0; i < 3; i++) begin
      bad_par = i == 1;
      run(32'h00000100, 1'h0, 1'h0, 1'h0, 5'h1);
      check(par_err_out, i > 0);
    end
    bank_present_in = 4'h9;
    run(32'h0C100000, 1'h0, 1'h0, 1'h0, 5'h1);
    check({errs, reqs}, {32'h1, 32'h0});
    run(32'h24100000, 1'h0, 1'h0, 1'h0, 5'h1);
    check(bank, 4'h8);
    finish_test();
  end
endmodule
